// *** logic/mbt_core.sv ***
// Execution core for moves, bit ops, branches, skips, table reads and misc ops
`timescale 1ns/1ps
// Behaviour
// - Moves and immediate load: one cycle, no flags
// - Bit clear/set touches selected bit only
// - Bit index selects positions zero to seven
// - Program counter changes take two cycles
// - Return with value loads working register
// - Taken skip two cycles, untaken one
// - Bit test skips on zero or one
// - Zero test to working copies byte, skips on zero
// - Increment, write back, skip on zero
// - Decrement skip; working forms keep memory
// - Table read: low to memory, high latched
// - Last-page variants read the last page
// - Pre-increment variants bump pointer first
// - Nibble swap to memory or working register
// - Watchdog restart clears powerdown, clears timeout unless TIMEOUT_EVENT is high, pulses WDT_RESTART
// - Halt enters power-down in one cycle
// - Operands address data sector zero only
module mbt_core
  import mbt_pkg::*;
(
  input  wire logic          CLK,
  input  wire logic          RESET,
  input  wire logic [15:0]   PROG_DATA,
  input  wire logic [7:0]    DMEM_RDATA,
  input  wire logic          WAKE,
  input  wire logic          TIMEOUT_EVENT,
  output logic      [11:0]   PROG_ADDR,
  output mbt_dmem_req_t      DMEM_REQ,
  output logic      [7:0]    WORKING_REG,
  output logic      [7:0]    TABLE_HIGH,
  output mbt_flags_t         FLAGS,
  output logic               POWER_DOWN,
  output logic               WDT_RESTART,
  output logic               INSTR_DONE
);
  logic [1:0]     q_reg, q_next;
  mbt_state_t     state_reg, state_next;
  logic [11:0]    pc_reg, pc_next, paddr_reg, paddr_next;
  logic [15:0]    instr_reg, instr_next;
  logic [7:0]     acc_reg, acc_next, tpl_reg, tpl_next, tph_reg, tph_next, tbh_reg, tbh_next;
  mbt_dmem_req_t  dreq_reg, dreq_next;
  mbt_flags_t     flg_reg, flg_next;
  logic           pd_reg, pd_next, wdt_reg, wdt_next, done_reg, done_next;
  logic [2:0]     sp_reg, sp_next;
  logic [11:0]    stack_mem [STACK_DEPTH];
  logic           push_en;
  logic           wake_meta_reg, wake_sync_reg;
  logic [7:0]     rd, wval;
  logic           wr_mem, skip;
  logic [11:0]    pc_inc, taddr;
  logic [3:0]     cls, sub;
  logic [2:0]     bi;
  logic           ex;

  assign cls    = instr_reg[15:12];
  assign sub    = instr_reg[11:8];
  assign bi     = instr_reg[10:8];
  assign pc_inc = pc_reg + 12'h001;
  assign ex     = (state_reg == ST_RUN) && (q_reg == PH_EXEC);
  assign taddr  = {(instr_reg[TAB_LAST_BIT] ? LAST_PAGE : tph_reg[3:0]), tpl_reg};

  always_comb begin
    q_next     = q_reg + 2'h1;
    state_next = state_reg;
    pc_next    = pc_reg;
    paddr_next = paddr_reg;
    instr_next = instr_reg;
    acc_next   = acc_reg;
    tpl_next   = tpl_reg;
    tph_next   = tph_reg;
    tbh_next   = tbh_reg;
    dreq_next  = dreq_reg;
    dreq_next.we = 1'b0;
    flg_next   = flg_reg;
    pd_next    = pd_reg;
    wdt_next   = 1'b0;
    done_next  = 1'b0;
    sp_next    = sp_reg;
    push_en    = 1'b0;
    wval       = RST_BYTE;
    wr_mem     = 1'b0;
    skip       = 1'b0;
    if (dreq_reg.addr == ADDR_TPL) begin
      rd = tpl_reg;
    end else if (dreq_reg.addr == ADDR_TPH) begin
      rd = tph_reg;
    end else if (dreq_reg.addr == ADDR_TBH) begin
      rd = tbh_reg;
    end else begin
      rd = DMEM_RDATA;
    end
    case (q_reg)
      PH_END: begin
        paddr_next = (state_reg == ST_TABLE) ? taddr : pc_reg;
      end
      PH_DECODE: begin
        if (state_reg == ST_RUN) begin
          instr_next     = PROG_DATA;
          dreq_next.addr = PROG_DATA[7:0];
        end
      end
      PH_EXEC: begin
        case (state_reg)
          ST_RUN: begin
            pc_next   = pc_inc;
            done_next = 1'b1;
            case (cls)
              CL_MOVLD: acc_next = rd;
              CL_MOVST: begin
                wval   = acc_reg;
                wr_mem = 1'b1;
              end
              CL_BCLR: begin
                wval   = rd & ~(8'h01 << bi);
                wr_mem = 1'b1;
              end
              CL_BSET: begin
                wval   = rd | (8'h01 << bi);
                wr_mem = 1'b1;
              end
              CL_BSZ:  skip = ~rd[bi];
              CL_BSNZ: skip = rd[bi];
              CL_BYTE: begin
                case (sub)
                  BY_SZ:  skip = (rd == 8'h00);
                  BY_SNZ: skip = (rd != 8'h00);
                  BY_SZA: begin
                    acc_next = rd;
                    skip     = (rd == 8'h00);
                  end
                  BY_SIZ: begin
                    wval   = rd + 8'h01;
                    wr_mem = 1'b1;
                    skip   = (wval == 8'h00);
                  end
                  BY_SDZ: begin
                    wval   = rd - 8'h01;
                    wr_mem = 1'b1;
                    skip   = (wval == 8'h00);
                  end
                  BY_INCREMENT_TEST_TO_WORKING: begin
                    wval     = rd + 8'h01;
                    acc_next = wval;
                    skip     = (wval == 8'h00);
                  end
                  BY_DECREMENT_TEST_TO_WORKING: begin
                    wval     = rd - 8'h01;
                    acc_next = wval;
                    skip     = (wval == 8'h00);
                  end
                  BY_CLR: begin
                    wval   = 8'h00;
                    wr_mem = 1'b1;
                  end
                  BY_SET: begin
                    wval   = 8'hff;
                    wr_mem = 1'b1;
                  end
                  BY_SWAP: begin
                    wval   = {rd[3:0], rd[7:4]};
                    wr_mem = 1'b1;
                  end
                  BY_NIBBLE_EXCHANGE_TO_WORKING: acc_next = {rd[3:0], rd[7:4]};
                  default: begin
                  end
                endcase
              end
              CL_TAB: begin
                if (instr_reg[TAB_INC_BIT]) begin
                  tpl_next = tpl_reg + 8'h01;
                end
                state_next = ST_TABLE;
                done_next  = 1'b0;
              end
              CL_JMP: begin
                pc_next    = instr_reg[11:0];
                state_next = ST_DUMMY;
                done_next  = 1'b0;
              end
              CL_CALL: begin
                push_en    = 1'b1;
                sp_next    = sp_reg + 3'h1;
                pc_next    = instr_reg[11:0];
                state_next = ST_DUMMY;
                done_next  = 1'b0;
              end
              CL_MISC: begin
                case (sub)
                  MS_RET, MS_INTERRUPT_RETURN, MS_RETV: begin
                    sp_next    = sp_reg - 3'h1;
                    pc_next    = stack_mem[sp_reg - 3'h1];
                    state_next = ST_DUMMY;
                    done_next  = 1'b0;
                    if (sub == MS_RETV) begin
                      acc_next = instr_reg[7:0];
                    end
                  end
                  MS_WDT: begin
                    flg_next.timeout   = 1'b0;
                    flg_next.powerdown = 1'b0;
                    wdt_next           = 1'b1;
                  end
                  MS_HALT: begin
                    flg_next.timeout   = 1'b0;
                    flg_next.powerdown = 1'b1;
                    pd_next            = 1'b1;
                    state_next         = ST_HALT;
                  end
                  MS_MOVI: acc_next = instr_reg[7:0];
                  default: begin
                  end
                endcase
              end
              default: begin
              end
            endcase
            if (skip) begin
              pc_next    = pc_reg + 12'h002;
              state_next = ST_DUMMY;
              done_next  = 1'b0;
            end
          end
          ST_DUMMY: begin
            state_next = ST_RUN;
            done_next  = 1'b1;
          end
          ST_TABLE: begin
            wval       = PROG_DATA[7:0];
            wr_mem     = 1'b1;
            tbh_next   = PROG_DATA[15:8];
            state_next = ST_RUN;
            done_next  = 1'b1;
          end
          default: begin
            if (wake_sync_reg) begin
              pd_next    = 1'b0;
              state_next = ST_RUN;
            end
          end
        endcase
        if (wr_mem) begin
          if (dreq_reg.addr == ADDR_TPL) begin
            tpl_next = wval;
          end else if (dreq_reg.addr == ADDR_TPH) begin
            tph_next = wval;
          end else if (dreq_reg.addr == ADDR_TBH) begin
            tbh_next = wval;
          end else begin
            dreq_next.we    = 1'b1;
            dreq_next.wdata = wval;
          end
        end
      end
      default: begin
      end
    endcase
    if (TIMEOUT_EVENT) begin
      flg_next.timeout = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      q_reg     <= PH_FETCH;
      state_reg <= ST_RUN;
      pc_reg    <= RST_PC;
      paddr_reg <= RST_PC;
      instr_reg <= 16'h0000;
      acc_reg   <= RST_BYTE;
      tpl_reg   <= RST_BYTE;
      tph_reg   <= RST_BYTE;
      tbh_reg   <= RST_BYTE;
      dreq_reg  <= '0;
      flg_reg   <= '0;
      pd_reg    <= 1'b0;
      wdt_reg   <= 1'b0;
      done_reg  <= 1'b0;
      sp_reg    <= RST_SP;
    end else begin
      q_reg     <= q_next;
      state_reg <= state_next;
      pc_reg    <= pc_next;
      paddr_reg <= paddr_next;
      instr_reg <= instr_next;
      acc_reg   <= acc_next;
      tpl_reg   <= tpl_next;
      tph_reg   <= tph_next;
      tbh_reg   <= tbh_next;
      dreq_reg  <= dreq_next;
      flg_reg   <= flg_next;
      pd_reg    <= pd_next;
      wdt_reg   <= wdt_next;
      done_reg  <= done_next;
      sp_reg    <= sp_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (push_en) begin
      stack_mem[sp_reg] <= pc_inc;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      wake_meta_reg <= 1'b0;
      wake_sync_reg <= 1'b0;
    end else begin
      wake_meta_reg <= WAKE;
      wake_sync_reg <= wake_meta_reg;
    end
  end

  assign PROG_ADDR   = paddr_reg;
  assign DMEM_REQ    = dreq_reg;
  assign WORKING_REG = acc_reg;
  assign TABLE_HIGH  = tbh_reg;
  assign FLAGS       = flg_reg;
  assign POWER_DOWN  = pd_reg;
  assign WDT_RESTART = wdt_reg;
  assign INSTR_DONE  = done_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  chk_jump_two: assert property (ex && cls == CL_JMP |=> (state_reg == ST_DUMMY)[*4] ##1 state_reg == ST_RUN)
    else $error("jump did not take two cycles");
  chk_skip_untaken: assert property (ex && cls == CL_BSZ && rd[bi] |=> (state_reg == ST_RUN)[*4])
    else $error("untaken skip not one cycle");
  chk_bit_clear: assert property (ex && cls == CL_BCLR && dreq_reg.addr > ADDR_TBH
    |=> DMEM_REQ.we && DMEM_REQ.wdata == ($past(rd) & ~(8'h01 << $past(bi))))
    else $error("bit clear wrote wrong value");
  chk_table_dest: assert property (state_reg == ST_TABLE && q_reg == PH_EXEC
    |=> TABLE_HIGH == $past(PROG_DATA[15:8]))
    else $error("table high byte not latched");
  chk_call_push: assert property (ex && cls == CL_CALL |=> sp_reg == $past(sp_reg) + 3'h1)
    else $error("call did not push");
  chk_ret_value: assert property (ex && cls == CL_MISC && sub == MS_RETV
    |=> WORKING_REG == $past(instr_reg[7:0]) && pc_reg == stack_mem[sp_reg])
    else $error("return with value wrong");
  chk_wdt_clear: assert property (ex && cls == CL_MISC && sub == MS_WDT && !TIMEOUT_EVENT
    |=> !FLAGS.timeout && !FLAGS.powerdown && WDT_RESTART)
    else $error("watchdog restart left flags set");
  chk_flags_hold: assert property (!ex && !TIMEOUT_EVENT |=> $stable(FLAGS))
    else $error("flags changed without cause");
  chk_halt_pd: assert property (ex && cls == CL_MISC && sub == MS_HALT |=> POWER_DOWN && FLAGS.powerdown)
    else $error("halt did not power down");
  chk_inc_skip: assert property (ex && cls == CL_BYTE && sub == BY_SIZ && rd == 8'hff
    |=> state_reg == ST_DUMMY && pc_reg == $past(pc_reg) + 12'h002)
    else $error("increment skip not taken");
endmodule // mbt_core

// *** logic/mbt_pkg.sv ***
// Constants, encodings and carrier types for the move/branch/table core
package mbt_pkg;
  localparam int PW  = 16;
  localparam int PCW = 12;
  localparam int DW  = 8;
  localparam int SPW = 3;
  localparam int STACK_DEPTH = 8;

  // Instruction classes in bits 15:12
  localparam logic [3:0] CL_MISC  = 4'h0;
  localparam logic [3:0] CL_MOVLD = 4'h1;
  localparam logic [3:0] CL_MOVST = 4'h2;
  localparam logic [3:0] CL_BCLR  = 4'h3;
  localparam logic [3:0] CL_BSET  = 4'h4;
  localparam logic [3:0] CL_BSZ   = 4'h5;
  localparam logic [3:0] CL_BSNZ  = 4'h6;
  localparam logic [3:0] CL_BYTE  = 4'h7;
  localparam logic [3:0] CL_TAB   = 4'h8;
  localparam logic [3:0] CL_JMP   = 4'he;
  localparam logic [3:0] CL_CALL  = 4'hf;

  // Sub-codes in bits 11:8 for the miscellaneous class
  localparam logic [3:0] MS_NOP  = 4'h0;
  localparam logic [3:0] MS_RET  = 4'h1;
  localparam logic [3:0] MS_INTERRUPT_RETURN = 4'h2;
  localparam logic [3:0] MS_WDT  = 4'h3;
  localparam logic [3:0] MS_HALT = 4'h4;
  localparam logic [3:0] MS_RETV = 4'h5;
  localparam logic [3:0] MS_MOVI = 4'h6;

  // Sub-codes in bits 11:8 for the byte class
  localparam logic [3:0] BY_SZ    = 4'h0;
  localparam logic [3:0] BY_SNZ   = 4'h1;
  localparam logic [3:0] BY_SZA   = 4'h2;
  localparam logic [3:0] BY_SIZ   = 4'h3;
  localparam logic [3:0] BY_SDZ   = 4'h4;
  localparam logic [3:0] BY_INCREMENT_TEST_TO_WORKING  = 4'h5;
  localparam logic [3:0] BY_DECREMENT_TEST_TO_WORKING  = 4'h6;
  localparam logic [3:0] BY_CLR   = 4'h7;
  localparam logic [3:0] BY_SET   = 4'h8;
  localparam logic [3:0] BY_SWAP  = 4'h9;
  localparam logic [3:0] BY_NIBBLE_EXCHANGE_TO_WORKING = 4'ha;

  // Table class option bits
  localparam int TAB_LAST_BIT = 8;
  localparam int TAB_INC_BIT  = 9;
  localparam logic [3:0] LAST_PAGE = 4'hf;

  // Special registers in data sector 0
  localparam logic [7:0] ADDR_TPL = 8'h07;
  localparam logic [7:0] ADDR_TPH = 8'h08;
  localparam logic [7:0] ADDR_TBH = 8'h09;

  // Phases of one instruction cycle
  localparam logic [1:0] PH_FETCH  = 2'h0;
  localparam logic [1:0] PH_DECODE = 2'h1;
  localparam logic [1:0] PH_EXEC   = 2'h2;
  localparam logic [1:0] PH_END    = 2'h3;

  localparam logic [11:0] RST_PC  = 12'h000;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [2:0]  RST_SP  = 3'h0;

  typedef enum logic [1:0] {ST_RUN, ST_DUMMY, ST_TABLE, ST_HALT} mbt_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
  } mbt_dmem_req_t;

  typedef struct packed {
    logic timeout;
    logic powerdown;
  } mbt_flags_t;
endpackage

// *** dv/mbt_mem_model.sv ***
// Program memory and data sector zero model for the core's far side
`timescale 1ns/1ps
module mbt_mem_model
  import mbt_pkg::*;
(
  input  wire logic          clk,
  input  wire logic [11:0]   prog_addr,
  input  mbt_dmem_req_t      dmem_req,
  output logic      [15:0]   prog_data,
  output logic      [7:0]    dmem_rdata
);
  logic [15:0] prog_mem [0:4095];
  logic [7:0]  data_mem [0:255];

  // Same-cycle program word, also used by table reads
  assign prog_data  = prog_mem[prog_addr];
  // Byte address reaches sector zero only
  assign dmem_rdata = data_mem[dmem_req.addr];

  // Write lands on the edge ending the strobe cycle
  always @(posedge clk) begin
    if (dmem_req.we === 1'b1) begin
      data_mem[dmem_req.addr] <= dmem_req.wdata;
    end
  end
endmodule // mbt_mem_model

// *** dv/mcu_move_branch_table_misc_ops_tb.sv ***
// Self-checking bench for the move, branch, table and misc core
`timescale 1ns/1ps
module mcu_move_branch_table_misc_ops_tb;
  import mbt_pkg::*;
  logic          clk;
  logic          reset;
  logic          wake;
  logic          timeout_event;
  logic [15:0]   prog_data;
  logic [7:0]    dmem_rdata;
  logic [11:0]   prog_addr;
  mbt_dmem_req_t dmem_req;
  logic [7:0]    working_reg;
  logic [7:0]    table_high;
  mbt_flags_t    flags;
  logic          power_down;
  logic          wdt_restart;
  logic          instr_done;
  int            failures = 0;
  int            comparisons = 0;
  logic [15:0]   prog [0:29] = '{16'h065a, 16'h2020, 16'h3120, 16'h4720, 16'h1021, 16'h7021, 16'h06ff,
    16'h7322, 16'h06ff, 16'h7623, 16'h7224, 16'h5020, 16'h06ff, 16'h6720, 16'h06ff, 16'h7920, 16'h7a24,
    16'h7725, 16'h7826, 16'h0680, 16'h2007, 16'h0602, 16'h2008, 16'h8027, 16'h8328, 16'hf100, 16'h7429,
    16'h06ff, 16'h0300, 16'he040};
  logic [7:0]    chk_addr [0:9] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29};
  logic [7:0]    chk_val  [0:9] = '{8'h8d, 8'h00, 8'h00, 8'h05, 8'h3c, 8'h00, 8'hff, 8'hef, 8'h34, 8'h00};

  mbt_core u_dut (
    .CLK           (clk),
    .RESET         (reset),
    .PROG_DATA     (prog_data),
    .DMEM_RDATA    (dmem_rdata),
    .WAKE          (wake),
    .TIMEOUT_EVENT (timeout_event),
    .PROG_ADDR     (prog_addr),
    .DMEM_REQ      (dmem_req),
    .WORKING_REG   (working_reg),
    .TABLE_HIGH    (table_high),
    .FLAGS         (flags),
    .POWER_DOWN    (power_down),
    .WDT_RESTART   (wdt_restart),
    .INSTR_DONE    (instr_done)
  );

  mbt_mem_model u_mem (
    .clk        (clk),
    .prog_addr  (prog_addr),
    .dmem_req   (dmem_req),
    .prog_data  (prog_data),
    .dmem_rdata (dmem_rdata)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits for retirement, checks cycle count and working register
  task automatic step(input int exp_cyc, input logic [7:0] exp_a);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (instr_done !== 1'b1 && n < 40);
    if (exp_cyc != 0) begin
      check(16'(n), 16'(exp_cyc));
    end
    check({8'h00, working_reg}, {8'h00, exp_a});
  endtask

  task automatic close_out;
    $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(20 * 3000);
    failures++;
    $display("Error at %0t: run did not finish", $time);
    close_out();
  end

  initial begin
    reset = 1'b1;
    wake = 1'b0;
    timeout_event = 1'b0;
    for (int i = 0; i < 4096; i++) u_mem.prog_mem[i] = 16'h0000;
    for (int i = 0; i < 256; i++) u_mem.data_mem[i] = 8'h00;
    for (int i = 0; i < 30; i++) u_mem.prog_mem[i] = prog[i];
    u_mem.prog_mem[12'h100] = 16'h0577;
    u_mem.prog_mem[12'h040] = 16'h0400;
    u_mem.prog_mem[12'h041] = 16'h0611;
    u_mem.prog_mem[12'h042] = 16'h5720;
    u_mem.prog_mem[12'h043] = 16'h7120;
    u_mem.prog_mem[12'h044] = 16'h06ff;
    u_mem.prog_mem[12'h045] = 16'h7521;
    u_mem.prog_mem[12'h046] = 16'hf050;
    u_mem.prog_mem[12'h047] = 16'hf060;
    u_mem.prog_mem[12'h048] = 16'h0000;
    u_mem.prog_mem[12'h050] = 16'h0100;
    u_mem.prog_mem[12'h060] = 16'h0200;
    u_mem.prog_mem[12'h280] = 16'hbeef;
    u_mem.prog_mem[12'hf81] = 16'h1234;
    u_mem.data_mem[8'h22] = 8'hff;
    u_mem.data_mem[8'h23] = 8'h05;
    u_mem.data_mem[8'h24] = 8'h3c;
    u_mem.data_mem[8'h25] = 8'haa;
    u_mem.data_mem[8'h29] = 8'h01;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    // Moves and bit operations
    step(0, 8'h5a);
    timeout_event = 1'b1;
    @(negedge clk);
    timeout_event = 1'b0;
    check({15'h0, flags.timeout}, 16'h0001);
    // One cycle already spent on the pulse
    step(3, 8'h5a);
    step(4, 8'h5a);
    step(4, 8'h5a);
    step(4, 8'h00);
    $display("Test moves and bits done");
    // Skips and byte operations
    step(8, 8'h00);
    step(8, 8'h00);
    step(4, 8'h04);
    step(4, 8'h3c);
    step(8, 8'h3c);
    step(8, 8'h3c);
    step(4, 8'h3c);
    step(4, 8'hc3);
    step(4, 8'hc3);
    step(4, 8'hc3);
    $display("Test skips and byte ops done");
    // Table reads
    step(4, 8'h80);
    step(4, 8'h80);
    step(4, 8'h02);
    step(4, 8'h02);
    step(8, 8'h02);
    check({8'h00, table_high}, 16'h00be);
    step(8, 8'h02);
    check({8'h00, table_high}, 16'h0012);
    $display("Test table reads done");
    // Branches, watchdog restart and halt
    step(8, 8'h02);
    step(8, 8'h77);
    step(8, 8'h77);
    check({15'h0, flags.timeout}, 16'h0001);
    step(4, 8'h77);
    check({15'h0, wdt_restart}, 16'h0001);
    check({14'h0, flags}, 16'h0000);
    step(8, 8'h77);
    for (int k = 0; k < 40 && power_down !== 1'b1; k++) @(negedge clk);
    check({15'h0, power_down}, 16'h0001);
    check({15'h0, flags.powerdown}, 16'h0001);
    repeat (12) @(negedge clk);
    check({4'h0, prog_addr}, 16'h0041);
    wake = 1'b1;
    for (int k = 0; k < 60 && working_reg !== 8'h11; k++) @(negedge clk);
    wake = 1'b0;
    check({8'h00, working_reg}, 16'h0011);
    check({15'h0, power_down}, 16'h0000);
    // Untaken bit skip, byte skip, increment to working, plain and interrupt returns
    step(4, 8'h11);
    step(8, 8'h11);
    step(4, 8'h01);
    step(8, 8'h01);
    step(8, 8'h01);
    step(8, 8'h01);
    step(8, 8'h01);
    step(4, 8'h01);
    check({4'h0, prog_addr}, 16'h0048);
    $display("Test branches and misc done");
    for (int i = 0; i < 10; i++) begin
      check({8'h00, u_mem.data_mem[chk_addr[i]]}, {8'h00, chk_val[i]});
    end
    $display("Test memory contents done");
    close_out();
  end
endmodule // mcu_move_branch_table_misc_ops_tb
